//--- rtl/adc_calibration_sequencer.sv
/*
 * Calibration sequencer with decimating filter, coefficient correction,
 * APB register file and sync handling, all on core_clk_i.
 * Assumes raw_sample_i comes from the modulator fed by input_sel_o, with
 * raw_valid_i pulsing once per modulator cycle on the same clock.
 */
// Added by the designer: the placing of the registers and the APB register port.
// Notes on behaviour
// - Sync falling edge resets filter and slot, state kept
// - Shared clock plus common sync aligns updates
// - Every calibration command resets the filter
// - Subtract offset, then multiply by gain
// - 33-bit arithmetic, 16 or 24-bit result
// - Host may write offset and gain coefficients
// - Ready goes low when calibration finishes
// - Ready goes high within one modulator cycle
// - Mode 001: shorted, reference, settle, ready
// - Self-calibration uses the selected gain
// - Bipolar self-cal uses midscale and full
// - Mode 010 converts zero input, ready low
// - Mode 011 converts full input, ready low
// - Zero step alone keeps the slope factor
// - Unipolar endpoints, bipolar midscale to full
// - Mode 100: input zero, reference span
// - Mode 101 interleaves, rate drops sixfold
module adc_calibration_sequencer (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic sync_n_i,
	input wire logic signed [23:0] raw_sample_i,
	input wire logic raw_valid_i,
	output logic [1:0] input_sel_o,
	output logic [2:0] pga_gain_o,
	output logic bipolar_o,
	output logic filter_reset_o,
	output logic result_ready_n_o
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [23:0] apply_cal(input logic signed [23:0] raw,
		input logic signed [23:0] ofs, input logic [23:0] gain, input logic bip);
		logic signed [32:0] diff;
		logic signed [57:0] prod;
		logic signed [57:0] sum;
		diff = 33'(raw) - 33'(ofs);
		prod = 58'(diff) * $signed({34'h0, gain});
		sum = (prod >>> adc_cal_pkg::GAIN_FRAC)
			+ (bip ? $signed(58'(adc_cal_pkg::MIDSCALE)) : 58'sh0);
		if (sum < 58'sh0) begin
			return 24'h000000;
		end else if (sum > $signed(58'(adc_cal_pkg::UNI_SPAN))) begin
			return adc_cal_pkg::UNI_SPAN;
		end else begin
			return sum[23:0];
		end
	endfunction

	function automatic logic is_cal(input logic [2:0] m);
		return (m >= adc_cal_pkg::MODE_SELF) && (m <= adc_cal_pkg::MODE_BACKGROUND);
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0] ctrl_q;
	logic signed [23:0] offset_q;
	logic [23:0] gain_q;
	logic [23:0] result_q;
	adc_cal_pkg::cal_state_t state_q, state_d;
	logic [2:0] cal_mode_q;
	logic [2:0] slot_q, slot_d;
	logic [1:0] sel_d;
	logic sync_m_q, sync_s2_q, sync_s3_q, sync_lvl_q;
	logic sync_fall;
	logic wr_acc, rd_acc, cmd_start;
	logic [2:0] wr_mode;
	logic filt_clr, fsm_clr;
	logic signed [27:0] acc_q;
	logic [3:0] cnt_q;
	logic signed [23:0] filt_out_q;
	logic filt_valid_q;
	logic [45:0] num_q;
	logic [24:0] rem_q;
	logic [23:0] dvs_q;
	logic [5:0] div_cnt_q;
	logic div_start, div_done;
	logic [24:0] rem_n;
	logic set_offset, set_gain, publish, cal_done;
	logic bip;

	assign bip = ctrl_q[adc_cal_pkg::CTRL_BIPOLAR_BIT];
	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign rd_acc = psel_i && penable_i && !pwrite_i;
	assign wr_mode = pwdata_i[adc_cal_pkg::CTRL_MODE_LSB +: 3];
	assign cmd_start = wr_acc && (paddr_i == adc_cal_pkg::REG_CTRL) && is_cal(wr_mode);

	// ****************************************
	// Sync input
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_m_q <= 1'b1;
			sync_s2_q <= 1'b1;
			sync_s3_q <= 1'b1;
			sync_lvl_q <= 1'b1;
		end else begin
			sync_m_q <= sync_n_i;
			sync_s2_q <= sync_m_q;
			sync_s3_q <= sync_s2_q;
			if (sync_s2_q == sync_s3_q) begin
				sync_lvl_q <= sync_s3_q;
			end
		end
	end
	assign sync_fall = sync_lvl_q && !sync_s2_q && !sync_s3_q;

	// ****************************************
	// Decimating filter
	// ****************************************
	assign filt_clr = sync_fall || cmd_start || fsm_clr;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_q <= 28'sh0;
			cnt_q <= 4'h0;
			filt_out_q <= 24'sh0;
			filt_valid_q <= 1'b0;
		end else if (filt_clr || filter_reset_o) begin
			// Second clear drops the sample made on the old select
			acc_q <= 28'sh0;
			cnt_q <= 4'h0;
			filt_valid_q <= 1'b0;
		end else begin
			filt_valid_q <= 1'b0;
			if (raw_valid_i) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == adc_cal_pkg::DECIM_LAST) begin
					filt_out_q <= 24'((acc_q + 28'(raw_sample_i)) >>> adc_cal_pkg::DECIM_LOG2);
					filt_valid_q <= 1'b1;
					acc_q <= 28'sh0;
				end else begin
					acc_q <= acc_q + 28'(raw_sample_i);
				end
			end
		end
	end

	// ****************************************
	// Gain divider
	// ****************************************
	assign rem_n = {rem_q[23:0], num_q[45]};
	assign div_done = (state_q == adc_cal_pkg::ST_DIV) && (div_cnt_q == 6'h0);
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			num_q <= 46'h0;
			rem_q <= 25'h0;
			dvs_q <= 24'h1;
			div_cnt_q <= 6'h0;
		end else if (div_start) begin
			num_q <= {bip ? adc_cal_pkg::BIP_SPAN : adc_cal_pkg::UNI_SPAN, 22'h0};
			rem_q <= 25'h0;
			if (filt_out_q > offset_q) begin
				dvs_q <= 24'(filt_out_q - offset_q);
			end else begin
				dvs_q <= 24'h1;
			end
			div_cnt_q <= adc_cal_pkg::DIV_STEPS;
		end else if (div_cnt_q != 6'h0) begin
			div_cnt_q <= div_cnt_q - 6'h1;
			if (rem_n >= {1'b0, dvs_q}) begin
				rem_q <= rem_n - {1'b0, dvs_q};
				num_q <= {num_q[44:0], 1'b1};
			end else begin
				rem_q <= rem_n;
				num_q <= {num_q[44:0], 1'b0};
			end
		end
	end

	// ****************************************
	// Calibration sequence
	// ****************************************
	always_comb begin
		state_d = state_q;
		slot_d = slot_q;
		sel_d = input_sel_o;
		fsm_clr = 1'b0;
		div_start = 1'b0;
		set_offset = 1'b0;
		set_gain = 1'b0;
		publish = 1'b0;
		cal_done = 1'b0;
		if (cmd_start) begin
			slot_d = 3'h0;
			case (wr_mode)
				adc_cal_pkg::MODE_SELF: begin
					state_d = adc_cal_pkg::ST_ZERO;
					sel_d = adc_cal_pkg::SEL_SHORT;
				end
				adc_cal_pkg::MODE_SYS_ZERO, adc_cal_pkg::MODE_SYS_OFFSET: begin
					state_d = adc_cal_pkg::ST_ZERO;
					sel_d = adc_cal_pkg::SEL_INPUT;
				end
				adc_cal_pkg::MODE_SYS_FULL: begin
					state_d = adc_cal_pkg::ST_FULL;
					sel_d = adc_cal_pkg::SEL_INPUT;
				end
				default: begin
					state_d = adc_cal_pkg::ST_BG;
					sel_d = adc_cal_pkg::SEL_SHORT;
				end
			endcase
		end else if (wr_acc && (paddr_i == adc_cal_pkg::REG_CTRL)
			&& state_q == adc_cal_pkg::ST_BG) begin
			state_d = adc_cal_pkg::ST_RUN;
			sel_d = adc_cal_pkg::SEL_INPUT;
			fsm_clr = 1'b1;
		end else begin
			case (state_q)
				adc_cal_pkg::ST_ZERO: begin
					if (filt_valid_q) begin
						set_offset = 1'b1;
						fsm_clr = 1'b1;
						if (cal_mode_q == adc_cal_pkg::MODE_SYS_ZERO) begin
							state_d = adc_cal_pkg::ST_RUN;
							cal_done = 1'b1;
						end else begin
							state_d = adc_cal_pkg::ST_FULL;
							sel_d = adc_cal_pkg::SEL_REF;
						end
					end
				end
				adc_cal_pkg::ST_FULL: begin
					if (filt_valid_q) begin
						div_start = 1'b1;
						state_d = adc_cal_pkg::ST_DIV;
					end
				end
				adc_cal_pkg::ST_DIV: begin
					if (div_done) begin
						set_gain = 1'b1;
						fsm_clr = 1'b1;
						sel_d = adc_cal_pkg::SEL_INPUT;
						if (cal_mode_q == adc_cal_pkg::MODE_SYS_FULL) begin
							state_d = adc_cal_pkg::ST_RUN;
							cal_done = 1'b1;
						end else if (cal_mode_q == adc_cal_pkg::MODE_BACKGROUND) begin
							state_d = adc_cal_pkg::ST_BG;
							slot_d = 3'h2;
						end else begin
							state_d = adc_cal_pkg::ST_SETTLE;
						end
					end
				end
				adc_cal_pkg::ST_SETTLE: begin
					if (filt_valid_q) begin
						publish = 1'b1;
						state_d = adc_cal_pkg::ST_RUN;
					end
				end
				adc_cal_pkg::ST_BG: begin
					if (filt_valid_q) begin
						if (slot_q == 3'h0) begin
							set_offset = 1'b1;
							fsm_clr = 1'b1;
							sel_d = adc_cal_pkg::SEL_REF;
							slot_d = 3'h1;
						end else if (slot_q == 3'h1) begin
							div_start = 1'b1;
							state_d = adc_cal_pkg::ST_DIV;
						end else if (slot_q == adc_cal_pkg::BG_LAST_SLOT) begin
							publish = 1'b1;
							fsm_clr = 1'b1;
							sel_d = adc_cal_pkg::SEL_SHORT;
							slot_d = 3'h0;
						end else begin
							slot_d = slot_q + 3'h1;
						end
					end
				end
				default: begin
					if (filt_valid_q) begin
						publish = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= adc_cal_pkg::ST_RUN;
			slot_q <= 3'h0;
			cal_mode_q <= adc_cal_pkg::MODE_NORMAL;
			input_sel_o <= adc_cal_pkg::SEL_INPUT;
			filter_reset_o <= 1'b0;
		end else begin
			state_q <= state_d;
			slot_q <= sync_fall ? 3'h0 : slot_d;
			input_sel_o <= sel_d;
			filter_reset_o <= filt_clr;
			if (cmd_start) begin
				cal_mode_q <= wr_mode;
			end
		end
	end

	// ****************************************
	// Coefficients and result
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			offset_q <= $signed(adc_cal_pkg::OFFSET_RESET);
			gain_q <= adc_cal_pkg::GAIN_RESET;
			result_q <= 24'h000000;
		end else begin
			if (set_offset) begin
				offset_q <= filt_out_q;
			end else if (wr_acc && paddr_i == adc_cal_pkg::REG_OFFSET) begin
				offset_q <= pwdata_i[23:0];
			end
			if (set_gain) begin
				gain_q <= (|num_q[45:24]) ? 24'hffffff : num_q[23:0];
			end else if (wr_acc && paddr_i == adc_cal_pkg::REG_GAIN) begin
				gain_q <= pwdata_i[23:0];
			end
			if (publish) begin
				result_q <= apply_cal(filt_out_q, offset_q, gain_q, bip);
			end
		end
	end

	// ****************************************
	// Ready output
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			result_ready_n_o <= 1'b1;
		end else if (publish || cal_done) begin
			result_ready_n_o <= 1'b0;
		end else if (cmd_start || sync_fall) begin
			result_ready_n_o <= 1'b1;
		end else if (rd_acc && paddr_i == adc_cal_pkg::REG_DATA) begin
			result_ready_n_o <= 1'b1;
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= adc_cal_pkg::CTRL_RESET;
			pga_gain_o <= 3'h0;
			bipolar_o <= 1'b0;
		end else begin
			if (wr_acc && paddr_i == adc_cal_pkg::REG_CTRL) begin
				ctrl_q <= pwdata_i[7:0];
			end
			pga_gain_o <= ctrl_q[adc_cal_pkg::CTRL_PGA_LSB +: 3];
			bipolar_o <= bip;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h00000000;
			pslverr_o <= 1'b0;
			pready_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= 1'b0;
			if (psel_i && !penable_i) begin
				prdata_o <= 32'h00000000;
				if (paddr_i == adc_cal_pkg::REG_CTRL) begin
					prdata_o <= {24'h0, ctrl_q};
				end else if (paddr_i == adc_cal_pkg::REG_STATUS) begin
					prdata_o <= {24'h0, slot_q, state_q, state_q != adc_cal_pkg::ST_RUN,
						result_ready_n_o};
				end else if (paddr_i == adc_cal_pkg::REG_OFFSET) begin
					prdata_o <= {8'h0, offset_q};
				end else if (paddr_i == adc_cal_pkg::REG_GAIN) begin
					prdata_o <= {8'h0, gain_q};
				end else if (paddr_i == adc_cal_pkg::REG_DATA) begin
					if (ctrl_q[adc_cal_pkg::CTRL_WORD24_BIT]) begin
						prdata_o <= {8'h0, result_q};
					end else begin
						prdata_o <= {16'h0, result_q[23:8]};
					end
				end else begin
					pslverr_o <= 1'b1;
				end
			end
		end
	end

endmodule

//--- rtl/adc_cal_pkg.sv
/*
 * Constants shared by the calibration sequencer: register offsets, field
 * positions, reset values, mode codes, input selects and arithmetic sizes.
 * Assumes a 32-bit APB master and a modulator that delivers signed samples.
 */
package adc_cal_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_OFFSET = 8'h08;
	localparam logic [7:0] REG_GAIN = 8'h0c;
	localparam logic [7:0] REG_DATA = 8'h10;

	// ****************************************
	// Control fields and reset values
	// ****************************************
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_BIPOLAR_BIT = 3;
	localparam int CTRL_WORD24_BIT = 4;
	localparam int CTRL_PGA_LSB = 5;
	localparam logic [7:0] CTRL_RESET = 8'h10;
	localparam logic [23:0] OFFSET_RESET = 24'h000000;
	localparam logic [23:0] GAIN_RESET = 24'h400000;

	// ****************************************
	// Mode codes and input selects
	// ****************************************
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_SELF = 3'h1;
	localparam logic [2:0] MODE_SYS_ZERO = 3'h2;
	localparam logic [2:0] MODE_SYS_FULL = 3'h3;
	localparam logic [2:0] MODE_SYS_OFFSET = 3'h4;
	localparam logic [2:0] MODE_BACKGROUND = 3'h5;
	localparam logic [1:0] SEL_INPUT = 2'h0;
	localparam logic [1:0] SEL_SHORT = 2'h1;
	localparam logic [1:0] SEL_REF = 2'h2;

	// ****************************************
	// Arithmetic and timing
	// ****************************************
	localparam int DECIM_LOG2 = 4;
	localparam logic [3:0] DECIM_LAST = 4'hf;
	localparam int GAIN_FRAC = 22;
	localparam logic [5:0] DIV_STEPS = 6'h2e;
	localparam logic [2:0] BG_LAST_SLOT = 3'h5;
	localparam logic [23:0] UNI_SPAN = 24'hffffff;
	localparam logic [23:0] BIP_SPAN = 24'h7fffff;
	localparam logic [23:0] MIDSCALE = 24'h800000;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_ZERO = 3'b001,
		ST_FULL = 3'b010,
		ST_DIV = 3'b011,
		ST_SETTLE = 3'b100,
		ST_BG = 3'b101
	} cal_state_t;

endpackage

//--- tb/adc_mod_model.sv
/* Modulator stand-in: one sample per modulator cycle from the selected node.
Assumes the testbench holds the node levels. */
module adc_mod_model #(
	parameter int MOD_DIV = 4
) (
	input wire logic clk_i,
	input wire logic [1:0] sel_i,
	input wire logic signed [23:0] ain_i,
	input wire logic signed [23:0] short_i,
	input wire logic signed [23:0] ref_i,
	output logic signed [23:0] sample_o,
	output logic valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Node select and strobe
	// ****
	int cnt = 0;
	logic signed [23:0] node;
	assign node = (sel_i == adc_cal_pkg::SEL_SHORT) ? short_i :
		(sel_i == adc_cal_pkg::SEL_REF) ? ref_i : ain_i;
	always @(posedge clk_i) begin
		cnt <= (cnt == MOD_DIV - 1) ? 0 : cnt + 1;
		valid_o <= (cnt == 0);
		// Off strobe the bus shows the inverted level
		sample_o <= (cnt == 0) ? node : ~node;
	end
endmodule

//--- tb/adc_cal_asserts.sv
/* Checker: port properties of the calibration sequencer.
Assumes the bind below reaches its one instance. */
module adc_cal_asserts (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic sync_n_i,
	input wire logic [1:0] input_sel_o,
	input wire logic [2:0] pga_gain_o,
	input wire logic bipolar_o,
	input wire logic filter_reset_o,
	input wire logic result_ready_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Properties
	// ****
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic ctrl_wr;
	logic cal_wr;
	assign ctrl_wr = psel_i && penable_i && pwrite_i && paddr_i == adc_cal_pkg::REG_CTRL;
	assign cal_wr = ctrl_wr && pwdata_i[2:0] inside {[3'h1:3'h5]};
	sequence sync_seen;
		$fell(sync_n_i) ##1 !sync_n_i [*3];
	endsequence
	sequence sys_start;
		ctrl_wr && pwdata_i[2:0] inside {[3'h2:3'h4]};
	endsequence
	a_sync_filter: assert property (sync_seen |-> ##[0:3] filter_reset_o)
		else $error("sync gave no filter reset");
	a_sync_ready: assert property (sync_seen |-> ##[0:3] result_ready_n_o)
		else $error("sync left ready low");
	a_cal_filter: assert property (cal_wr |-> ##[1:2] filter_reset_o)
		else $error("calibration start gave no filter reset");
	a_cal_busy: assert property (cal_wr |-> ##[1:4] result_ready_n_o)
		else $error("ready not high after calibration start");
	a_self_short: assert property (cal_wr && pwdata_i[2:0] == 3'h1
		|-> ##[1:3] input_sel_o == adc_cal_pkg::SEL_SHORT)
		else $error("self calibration did not pick shorted node");
	a_sys_input_first: assert property (sys_start
		|-> ##2 (input_sel_o == adc_cal_pkg::SEL_INPUT) [*8])
		else $error("system step left analog input");
	a_cfg_follow: assert property (ctrl_wr |-> ##2 pga_gain_o == $past(pwdata_i[7:5], 2)
		&& bipolar_o == $past(pwdata_i[3], 2))
		else $error("gain or range output wrong");
	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_sel_legal: assert property (input_sel_o != 2'h3)
		else $error("illegal input select");
endmodule

bind adc_calibration_sequencer adc_cal_asserts u_adc_cal_asserts (.core_clk_i, .rst_n_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .sync_n_i,
	.input_sel_o, .pga_gain_o, .bipolar_o, .filter_reset_o, .result_ready_n_o);

//--- tb/adc_calibration_sequencer_tb.sv
/* Testbench: APB master, sync driver and result checks for the sequencer.
Assumes the modulator model and checker in tb/ and the package in rtl/. */
module adc_calibration_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic sync_n_i = 1'b1;
	logic signed [23:0] raw_sample_i;
	logic raw_valid_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic [1:0] input_sel_o;
	logic [2:0] pga_gain_o;
	logic bipolar_o;
	logic filter_reset_o;
	logic result_ready_n_o;
	logic signed [23:0] analog_input_pin = 24'h100000;
	logic signed [23:0] s_node = 24'h0;
	logic signed [23:0] r_node = 24'h7fffff;
	logic signed [23:0] z;
	logic [23:0] d;
	logic [33:0] e;
	logic [33:0] exp_q[$];
	int error_cnt = 0;
	int cmp_count = 0;
	int seed = 27;

	always #2 core_clk_i = ~core_clk_i;

	adc_calibration_sequencer u_adc_calibration_sequencer (.core_clk_i, .rst_n_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.sync_n_i, .raw_sample_i, .raw_valid_i, .input_sel_o, .pga_gain_o, .bipolar_o,
		.filter_reset_o, .result_ready_n_o);
	adc_mod_model u_adc_mod_model (.clk_i(core_clk_i), .sel_i(input_sel_o), .ain_i(analog_input_pin),
		.short_i(s_node), .ref_i(r_node), .sample_o(raw_sample_i), .valid_o(raw_valid_i));

	// ****
	// Checks and bus tasks
	// ****
	task automatic cmp_w(input logic [31:0] got, input logic [31:0] x);
		cmp_count++;
		if (got !== x) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, x);
		end
	endtask

	task automatic tally_and_finish;
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Reads carry the expected word in d, writes the data
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic chk, input logic err);
		int n;
		exp_q.push_back({chk, err, d});
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= w ? d : 32'h0;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			tally_and_finish;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, x, 1'b1, 1'b0);
	endtask

	// Which 1 waits for a filter reset, 0 for ready low
	task automatic wait_for(input int which, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge core_clk_i);
			n++;
		end while ((which ? filter_reset_o : !result_ready_n_o) !== 1'b1 && n < lim);
		cmp_count++;
		if (n >= lim) begin
			error_cnt++;
			tally_and_finish;
		end
	endtask

	task automatic sync_pulse;
		@(posedge core_clk_i);
		sync_n_i <= 1'b0;
		wait_for(1, 8);
		cmp_w({31'h0, result_ready_n_o}, 32'h1);
		@(posedge core_clk_i);
		sync_n_i <= 1'b1;
	endtask

	task automatic cal(input logic [7:0] c);
		wr(8'h00, {24'h0, c});
		wait_for(1, 8);
		repeat (4) @(negedge core_clk_i);
		cmp_w({31'h0, result_ready_n_o}, 32'h1);
		wait_for(0, 3000);
		cmp_w({30'h0, adc_cal_pkg::SEL_INPUT}, {30'h0, input_sel_o});
		cmp_w({28'h0, pga_gain_o, bipolar_o}, {28'h0, c[7:5], c[3]});
	endtask

	always @(posedge core_clk_i) begin
		if (pready_o === 1'b1) begin
			e = exp_q.pop_front();
			if (e[33]) cmp_w(prdata_o, e[31:0]);
			cmp_w({31'h0, pslverr_o}, {31'h0, e[32]});
		end
	end

	// ****
	// Main sequence
	// ****
	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd(8'h00, 32'h10);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h400000);
		rd(8'h04, 32'h1);
		apb(1'b0, 8'h20, 32'h0, 1'b1, 1'b1);
		analog_input_pin <= 24'h100000 | 24'($random(seed) & 32'h0fffff);
		wr(8'h08, 32'h100);
		wr(8'h0c, 32'h200000);
		rd(8'h0c, 32'h200000);
		sync_pulse;
		wait_for(0, 3000);
		d = (analog_input_pin - 24'h100) >> 1;
		rd(8'h10, {8'h0, d});
		wr(8'h00, 32'h0);
		sync_pulse;
		wait_for(0, 3000);
		rd(8'h10, {16'h0, d[23:8]});
		for (int i = 0; i < 2; i++) begin
			z = 24'hff0000 | 24'($random(seed));
			r_node <= z + 24'h7fffff;
			s_node <= i ? z + 24'h5555 : z;
			analog_input_pin <= i ? z : z + 24'h1000;
			cal(i ? 8'h1c : 8'hb9);
			rd(8'h08, {8'h0, z});
			rd(8'h0c, 32'h400000);
			rd(8'h10, i ? 32'h800000 : 32'h801000);
		end
		analog_input_pin <= 24'hffff00;
		cal(8'h1a);
		rd(8'h08, 32'hffff00);
		analog_input_pin <= 24'h7ffeff;
		cal(8'h1b);
		rd(8'h0c, 32'h400000);
		wr(8'h0c, 32'h300000);
		analog_input_pin <= 24'h000040;
		cal(8'h1a);
		rd(8'h08, 32'h40);
		rd(8'h0c, 32'h300000);
		wr(8'h00, 32'h1d);
		wait_for(1, 8);
		wait_for(0, 3000);
		wr(8'h00, 32'h10);
		tally_and_finish;
	end
endmodule
